// ---- rtl/ioxp_defines.vh ----
// shared constants of the expander port and interrupt block
`ifndef IOXP_DEFINES_VH
`define IOXP_DEFINES_VH

// port geometry
`define IOXP_PIN_W 16
`define IOXP_PORT_W 8
`define IOXP_NPORT 2
`define IOXP_CMD_W 8

// reset values
`define IOXP_DIR_ALL_IN 16'hFFFF
`define IOXP_PINS_ZERO 16'h0000
`define IOXP_CMD_RESET 8'hFF
`define IOXP_PORT_ZERO 8'h00

// command pointer value that arms the false-clear hazard
`define IOXP_CMD_INPUT0 8'h00

// port select codes
`define IOXP_SEL_PORT0 1'b0
`define IOXP_SEL_PORT1 1'b1

// synchroniser depth
`define IOXP_SYNC_STAGES 2

`endif

// ---- rtl/ioxp_sync.v ----
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`include "ioxp_defines.vh"

module ioxp_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire rst,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    // first stage feeds only the second stage
    always @(posedge core_clk) begin
        if (rst) begin
            meta_q <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= asyncIn;
            stable_q <= meta_q;
        end
    end

    assign syncOut = stable_q;

endmodule // ioxp_sync

// ---- rtl/ioxp_port_int.v ----
// port direction, pin drive and change interrupt logic of the 16-bit expander
`timescale 1ns/1ps
`include "ioxp_defines.vh"

//  Contract
// [R1] hold reset until supply passes threshold, then initialise all state
// [R2] after reset all sixteen pins are inputs
// [R3] input pins have both drivers off, high impedance
// [R4] output pins driven high or low from the output register bit
// [R5] any edge on an input pin raises the interrupt
// [R6] interrupt withdrawn when inputs return to original levels
// [R7] reading the causing port clears at ack/nack bit after SCL rise
// [R8] change during the clearing ack pulse may be lost
// [R9] every later change after a clear is signalled again
// [R10] write traffic to other devices leaves interrupt untouched
// [R11] output pins never cause an interrupt
// [R12] output to input switch with differing level may interrupt falsely
// [R13] clear tracked per 8-pin port; one port read keeps other
// [R14] interrupt output is open drain, pulls low only
// [R15] pointer 00h plus foreign read-address ack falsely clears interrupt
// [R16] pointer keeps last written value after reads
// [R17] master should rewrite pointer away from 00h before other reads
// [R18] direction bit one means input, zero means output
// [R19] reads return the register chosen by the last command byte
// [R20] input register shows live pin levels, read only
// [R21] per-port snapshot at clearing read; interrupt while input pins differ
// [R22] pins synchronised before change detection
module ioxp_port_int (
    input wire core_clk,
    input wire rst,
    input wire porThreshold,
    input wire sclIn,
    input wire [`IOXP_PIN_W-1:0] pinIn,
    input wire [`IOXP_PIN_W-1:0] portDir,
    input wire [`IOXP_PIN_W-1:0] portOut,
    input wire readAckSlot,
    input wire readAckPort,
    input wire otherReadAck,
    input wire cmdWrEn,
    input wire [`IOXP_CMD_W-1:0] cmdWrData,
    output wire [`IOXP_PIN_W-1:0] pinOut,
    output wire [`IOXP_PIN_W-1:0] pinOe,
    output wire [`IOXP_PIN_W-1:0] inputPort,
    output wire [`IOXP_CMD_W-1:0] cmdPtr,
    output wire [`IOXP_NPORT-1:0] portIntPending,
    output wire intOut,
    output wire intOe
);

    // mismatch of input-configured pins of one port against its snapshot
    function portMismatch;
        input [`IOXP_PORT_W-1:0] levels;
        input [`IOXP_PORT_W-1:0] snap;
        input [`IOXP_PORT_W-1:0] dirIn;
        begin
            portMismatch = |((levels ^ snap) & dirIn);
        end
    endfunction

    wire porOk;
    wire sclSync;
    wire [`IOXP_PIN_W-1:0] pinSync;
    wire coreRst;
    wire sclRise;
    wire falseClear;
    wire [`IOXP_PIN_W-1:0] dirEff;
    wire [`IOXP_NPORT-1:0] mismatch;
    wire [`IOXP_NPORT-1:0] clearPort;

    reg sclPrev_q;
    reg initDone_q;
    reg [`IOXP_CMD_W-1:0] cmdPtr_q;
    reg [`IOXP_PIN_W-1:0] pinOut_q;
    reg [`IOXP_PIN_W-1:0] pinOe_q;
    reg [`IOXP_PIN_W-1:0] inputPort_q;
    reg [`IOXP_PIN_W-1:0] snap_q;
    reg [`IOXP_NPORT-1:0] pending_q;
    reg intOe_q;
    reg intOut_q;

    // bring threshold, serial clock and pins into the core clock
    ioxp_sync #(.WIDTH(1)) uPorSync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(porThreshold),
        .syncOut(porOk)
    );

    ioxp_sync #(.WIDTH(1)) uSclSync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(sclIn),
        .syncOut(sclSync)
    );

    ioxp_sync #(.WIDTH(`IOXP_PIN_W)) uPinSync ( // [R22]
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // stay in reset until supply is above the threshold
    assign coreRst = rst | ~porOk; // [R1]

    // serial clock rising edge on the synchronised copy
    always @(posedge core_clk) begin
        if (coreRst) begin
            sclPrev_q <= 1'b0;
        end else begin
            sclPrev_q <= sclSync;
        end
    end

    // no edge in the first cycle after reset: sclPrev_q wakes low while the idle line is high
    assign sclRise = sclSync & ~sclPrev_q & initDone_q;

    // first cycle after reset takes the starting snapshot
    always @(posedge core_clk) begin
        if (coreRst) begin
            initDone_q <= 1'b0;
        end else begin
            initDone_q <= 1'b1;
        end
    end

    // all pins forced to input until initialisation is done
    assign dirEff = initDone_q ? portDir : `IOXP_DIR_ALL_IN; // [R2] [R18]

    // command pointer changes only on a command byte write or on reset, which loads FFh
    always @(posedge core_clk) begin
        if (coreRst) begin
            cmdPtr_q <= `IOXP_CMD_RESET; // [R1]
        end else if (cmdWrEn) begin
            cmdPtr_q <= cmdWrData; // [R16] [R19]
        end
    end

    // pin drivers: off for inputs, output register level otherwise
    always @(posedge core_clk) begin
        if (coreRst) begin
            pinOe_q <= `IOXP_PINS_ZERO; // [R2]
            pinOut_q <= `IOXP_PINS_ZERO;
        end else begin
            pinOe_q <= ~dirEff; // [R3] [R4] [R18]
            pinOut_q <= portOut & ~dirEff; // [R4]
        end
    end

    // live pin levels regardless of direction
    always @(posedge core_clk) begin
        if (coreRst) begin
            inputPort_q <= `IOXP_PINS_ZERO;
        end else begin
            inputPort_q <= pinSync; // [R20]
        end
    end

    // foreign read-address ack while pointer rests on input port 0
    assign falseClear = sclRise & otherReadAck & (cmdPtr_q == `IOXP_CMD_INPUT0); // [R15] [R17]

    // per-port snapshot, clear and mismatch
    genvar p;
    generate
        for (p = 0; p < `IOXP_NPORT; p = p + 1) begin : gPort
            // clear when this port's byte was the one read, or on a foreign read-address ack with pointer 00h
            assign clearPort[p] = (sclRise & readAckSlot & (readAckPort == (p != 0))) | falseClear; // [R7] [R13]

            always @(posedge core_clk) begin
                if (coreRst) begin
                    snap_q[p*`IOXP_PORT_W +: `IOXP_PORT_W] <= `IOXP_PORT_ZERO;
                end else if (!initDone_q || clearPort[p]) begin
                    // level at the ack edge wins, so a change then is absorbed
                    snap_q[p*`IOXP_PORT_W +: `IOXP_PORT_W] <= pinSync[p*`IOXP_PORT_W +: `IOXP_PORT_W]; // [R8] [R21]
                end
            end

            // output pins masked; snapshot still reloads an output pin's level on a clear
            assign mismatch[p] = portMismatch(pinSync[p*`IOXP_PORT_W +: `IOXP_PORT_W],
                snap_q[p*`IOXP_PORT_W +: `IOXP_PORT_W],
                dirEff[p*`IOXP_PORT_W +: `IOXP_PORT_W]); // [R5] [R6] [R11] [R12]

            always @(posedge core_clk) begin
                if (coreRst || !initDone_q) begin
                    pending_q[p] <= 1'b0;
                end else begin
                    pending_q[p] <= mismatch[p] & ~clearPort[p]; // [R9] [R10] [R21]
                end
            end
        end
    endgenerate

    // open-drain request: drive low only while any port is pending
    always @(posedge core_clk) begin
        if (coreRst) begin
            intOe_q <= 1'b0;
            intOut_q <= 1'b0;
        end else begin
            intOe_q <= |pending_q; // [R14]
            intOut_q <= 1'b0; // [R14]
        end
    end

    assign pinOut = pinOut_q;
    assign pinOe = pinOe_q;
    assign inputPort = inputPort_q;
    assign cmdPtr = cmdPtr_q;
    assign portIntPending = pending_q;
    assign intOut = intOut_q;
    assign intOe = intOe_q;

endmodule // ioxp_port_int

// ---- tb/ioxp_chk.sv ----
// checker of pin drive, command pointer and interrupt timing
`timescale 1ns/1ps
module ioxp_chk (
    input wire core_clk,
    input wire rst,
    input wire porThreshold,
    input wire [15:0] pinIn,
    input wire [15:0] portDir,
    input wire [15:0] portOut,
    input wire cmdWrEn,
    input wire [7:0] cmdWrData,
    input wire [15:0] pinOut,
    input wire [15:0] pinOe,
    input wire [15:0] inputPort,
    input wire [7:0] cmdPtr,
    input wire [1:0] portIntPending,
    input wire intOut,
    input wire intOe
);
    logic [2:0] upCnt_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || !porThreshold);
    // cycles since reset and supply came good
    always @(posedge core_clk) begin
        if (rst || !porThreshold) upCnt_q <= 3'h0;
        else if (upCnt_q != 3'h7) upCnt_q <= upCnt_q + 3'h1;
    end
    chk_int_drain: assert property (intOut == 1'b0)
        else $error("int line driven high");
    chk_int_follow: assert property (intOe == $past(|portIntPending))
        else $error("int line not following pending");
    chk_in_hiz: assert property (upCnt_q == 3'h7 |-> pinOe == ~$past(portDir))
        else $error("driver enable wrong");
    chk_out_drive: assert property (upCnt_q == 3'h7 |-> pinOut == ($past(portOut) & ~$past(portDir)))
        else $error("drive level wrong");
    chk_in_mirror: assert property (upCnt_q == 3'h7 |-> inputPort == $past(pinIn, 3))
        else $error("input port not live");
    chk_cmd_load: assert property (cmdWrEn |=> cmdPtr == $past(cmdWrData))
        else $error("pointer not loaded");
    chk_cmd_hold: assert property (!cmdWrEn |=> $stable(cmdPtr))
        else $error("pointer moved");
    chk_out_quiet: assert property (portDir == 16'h0000 [*3] |=> portIntPending == 2'b00)
        else $error("output pin raised pending");
endmodule // ioxp_chk

// ---- tb/ioxp_host.sv ----
// bus master model: clocks ack bits and flags who acks
`timescale 1ns/1ps
module ioxp_host (
    input wire core_clk,
    output logic sclIn,
    output logic readAckSlot,
    output logic readAckPort,
    output logic otherReadAck
);
    // idle bus: clock high, no ack
    initial begin
        sclIn = 1'b1;
        readAckSlot = 1'b0;
        readAckPort = 1'b0;
        otherReadAck = 1'b0;
    end
    // one ack bit of 200 ns, flags held across the high phase
    task ackBit(input logic slot, input logic port, input logic other);
        begin
            @(posedge core_clk) #1 sclIn = 1'b0;
            readAckSlot = slot;
            readAckPort = port;
            otherReadAck = other;
            repeat (4) @(posedge core_clk);
            #1 sclIn = 1'b1;
            repeat (4) @(posedge core_clk);
            #1 readAckSlot = 1'b0;
            readAckPort = ~port;
            otherReadAck = 1'b0;
        end
    endtask
endmodule // ioxp_host

// ---- tb/ioxp_port_int_test.sv ----
// bench of the expander port and interrupt block
`timescale 1ns/1ps
module ioxp_port_int_test;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic porThreshold = 1'b1;
    logic [15:0] pinExt = 16'h0000;
    logic [15:0] portDir = 16'hFFFF;
    logic [15:0] portOut = 16'hA5C3;
    logic cmdWrEn = 1'b0;
    logic [7:0] cmdWrData = 8'h00;
    wire [15:0] pinIn, pinOut, pinOe, inputPort;
    wire [7:0] cmdPtr;
    wire [1:0] portIntPending;
    wire intOut, intOe, sclIn, readAckSlot, readAckPort, otherReadAck;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    // pin wire: driven bits win, the rest follow the outside level
    assign pinIn = (pinOe & pinOut) | (~pinOe & pinExt);
    ioxp_port_int dut_u (
        .core_clk(core_clk),
        .rst(rst),
        .porThreshold(porThreshold),
        .sclIn(sclIn),
        .pinIn(pinIn),
        .portDir(portDir),
        .portOut(portOut),
        .readAckSlot(readAckSlot),
        .readAckPort(readAckPort),
        .otherReadAck(otherReadAck),
        .cmdWrEn(cmdWrEn),
        .cmdWrData(cmdWrData),
        .pinOut(pinOut),
        .pinOe(pinOe),
        .inputPort(inputPort),
        .cmdPtr(cmdPtr),
        .portIntPending(portIntPending),
        .intOut(intOut),
        .intOe(intOe)
    );
    ioxp_host host_u (
        .core_clk(core_clk),
        .sclIn(sclIn),
        .readAckSlot(readAckSlot),
        .readAckPort(readAckPort),
        .otherReadAck(otherReadAck)
    );
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            summarize;
        end
    end
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task cmp(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task cmpInt(input logic [1:0] p, input logic e);
        cmp({12'h000, intOut, portIntPending, intOe}, {12'h000, 1'b0, p, e});
    endtask
    task cmdWr(input logic [7:0] v);
        cmdWrEn = 1'b1;
        cmdWrData = v;
        tick(1);
        cmdWrEn = 1'b0;
    endtask
    task summarize;
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // directions, drive levels, live inputs, quiet outputs
    task drive;
        portDir = 16'h0FF0;
        tick(5);
        cmp(pinOe, 16'hF00F);
        cmp(pinOut, 16'hA003);
        cmp(inputPort, 16'hA003);
        portDir = 16'h0000;
        tick(5);
        cmpInt(2'b00, 1'b0);
        portDir = 16'hFFFF;
        tick(5);
        cmpInt(2'b00, 1'b0);
    endtask
    // raise, withdraw, per-port clear, re-detect
    task irq;
        pinExt = 16'h0008;
        tick(5);
        cmpInt(2'b01, 1'b1);
        pinExt = 16'h0000;
        tick(5);
        cmpInt(2'b00, 1'b0);
        pinExt = 16'h0208;
        tick(5);
        cmpInt(2'b11, 1'b1);
        host_u.ackBit(1'b1, 1'b0, 1'b0);
        cmpInt(2'b10, 1'b1);
        host_u.ackBit(1'b1, 1'b1, 1'b0);
        cmpInt(2'b00, 1'b0);
        pinExt = 16'h0200;
        tick(5);
        cmpInt(2'b01, 1'b1);
    endtask
    // foreign read ack with pointer 00h, then with pointer moved
    task falseClr;
        cmdWr(8'h00);
        host_u.ackBit(1'b0, 1'b0, 1'b1);
        cmpInt(2'b00, 1'b0);
        cmp({8'h00, cmdPtr}, 16'h0000);
        pinExt = 16'h0201;
        tick(5);
        cmdWr(8'h02);
        host_u.ackBit(1'b0, 1'b0, 1'b1);
        host_u.ackBit(1'b0, 1'b0, 1'b0);
        cmpInt(2'b01, 1'b1);
        cmp({8'h00, cmdPtr}, 16'h0002);
    endtask
    // output pin ignored, switch back may interrupt, supply and reset restart
    task outPin;
        host_u.ackBit(1'b1, 1'b0, 1'b0);
        cmpInt(2'b00, 1'b0);
        pinExt = 16'h0200;
        portOut = 16'hA5C2;
        portDir = 16'hFFFE;
        tick(5);
        cmpInt(2'b00, 1'b0);
        portDir = 16'hFFFF;
        tick(5);
        cmpInt(2'b01, 1'b1);
        porThreshold = 1'b0;
        portDir = 16'hFFF0;
        tick(6);
        cmp(pinOe, 16'h0000);
        cmp({8'h00, cmdPtr}, 16'h00FF);
        cmpInt(2'b00, 1'b0);
        porThreshold = 1'b1;
        tick(9);
        cmp(pinOe, 16'h000F);
        cmdWr(8'h05);
        cmp({8'h00, cmdPtr}, 16'h0005);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        cmp({8'h00, cmdPtr}, 16'h00FF);
        tick(3);
        cmp(pinOe, 16'h0000);
    endtask
    // reset, then the scenarios in turn
    initial begin
        tick(10);
        cmp(pinOe, 16'h0000);
        cmp({8'h00, cmdPtr}, 16'h00FF);
        rst = 1'b0;
        tick(8);
        drive;
        irq;
        falseClr;
        outPin;
        summarize;
    end
endmodule // ioxp_port_int_test
bind ioxp_port_int ioxp_chk chk_u (
    .core_clk(core_clk),
    .rst(rst),
    .porThreshold(porThreshold),
    .pinIn(pinIn),
    .portDir(portDir),
    .portOut(portOut),
    .cmdWrEn(cmdWrEn),
    .cmdWrData(cmdWrData),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .inputPort(inputPort),
    .cmdPtr(cmdPtr),
    .portIntPending(portIntPending),
    .intOut(intOut),
    .intOe(intOe)
);
